// *** core/pio_ports.sv ***
// Five parallel I/O ports with APB register access
`timescale 1ns/10ps
module pio_ports #(
    parameter int ADDR_W = 8
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [pio_pkg::P0_W-1:0]   port0_pin_in,
    output logic      [pio_pkg::P0_W-1:0]   port0_pin_out,
    output logic      [pio_pkg::P0_W-1:0]   port0_pin_oe,
    input  wire logic [pio_pkg::P1_W-1:0]   port1_pin_in,
    output logic      [pio_pkg::P1_W-1:0]   port1_pin_out,
    output logic      [pio_pkg::P1_W-1:0]   port1_pin_oe,
    input  wire logic [pio_pkg::P2_W-1:0]   port2_pin_in,
    output logic      [pio_pkg::P2_W-1:0]   port2_pin_out,
    output logic      [pio_pkg::P2_W-1:0]   port2_pin_oe,
    input  wire logic [pio_pkg::P3_W-1:0]   port3_pin_in,
    output logic      [pio_pkg::P3_W-1:0]   port3_pin_out,
    output logic      [pio_pkg::P3_W-1:0]   port3_pin_oe,
    input  wire logic [pio_pkg::P4_W-1:0]   port4_pin_in,
    output logic      [pio_pkg::P4_W-1:0]   port4_pin_out,
    output logic      [pio_pkg::P4_W-1:0]   port4_pin_oe,
    input  wire logic                       dual_clock_mode,
    output logic                            ext_irq0_input,
    output logic                            ext_irq5_input,
    output logic                            low_freq_xtal_in,
    output logic      [pio_pkg::P3_W-1:0]   analog_pin_select
);
    import pio_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8 to reach every register");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Word index of an aligned address, all ones when misaligned or high
    function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] upper;
        upper = a >> 8;
        if (a[1:0] != 2'b00 || upper != '0) begin
            return 6'h3f;
        end
        return a[7:2];
    endfunction : word_index

    // Per-bit read: pin for inputs, latch for outputs
    function automatic logic [7:0] mix_read(input logic [7:0] pin,
                                            input logic [7:0] latch,
                                            input logic [7:0] dir);
        return (pin & ~dir) | (latch & dir);
    endfunction : mix_read

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [P0_W-1:0] port0_out_latch_reg, port0_out_latch_next;
    logic [P1_W-1:0] port1_out_latch_reg, port1_out_latch_next;
    logic [P2_W-1:0] port2_out_latch_reg, port2_out_latch_next;
    logic [P3_W-1:0] port3_out_latch_reg, port3_out_latch_next;
    logic [P4_W-1:0] port4_out_latch_reg, port4_out_latch_next;
    logic [P1_W-1:0] port1_direction_reg, port1_direction_next;
    logic [P3_W-1:0] port3_direction_reg, port3_direction_next;
    logic [P4_W-1:0] port4_direction_reg, port4_direction_next;
    logic [7:0]      conv_ctrl_reg,       conv_ctrl_next;
    logic [7:0]      ext_irq_control_reg, ext_irq_control_next;
    logic [31:0]     prdata_reg,          prdata_next;

    logic [5:0]  idx;
    logic        setup_phase;
    logic        write_access;
    logic        mapped;
    logic        read_only;
    logic [7:0]  read_value;
    logic        analog_input_disable;
    logic [CHAN_SEL_W-1:0] analog_channel_select;
    logic        ext_irq0_pin_select;
    logic [7:0]  analog_onehot;
    logic [7:0]  p1_read;
    logic [7:0]  p3_read;
    logic [7:0]  p4_read;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign idx          = word_index(paddr);
    assign setup_phase  = psel && !penable;
    assign write_access = psel && penable && pwrite && mapped && !read_only;
    assign read_only    = (idx == IDX_PORT0_PIN) || (idx == IDX_PORT2_PIN);
    assign mapped = (idx == IDX_PORT0_LATCH) || (idx == IDX_PORT1_LATCH) ||
                    (idx == IDX_PORT2_LATCH) || (idx == IDX_PORT3_LATCH) ||
                    (idx == IDX_PORT4_LATCH) || (idx == IDX_PORT0_PIN)   ||
                    (idx == IDX_PORT2_PIN)   || (idx == IDX_PORT1_DIR)   ||
                    (idx == IDX_PORT3_DIR)   || (idx == IDX_PORT4_DIR)   ||
                    (idx == IDX_CONV_CTRL1)  || (idx == IDX_EXT_IRQ_CTRL);

    // Control fields
    assign analog_input_disable  = conv_ctrl_reg[AIN_DISABLE_BIT];
    assign analog_channel_select =
        conv_ctrl_reg[CHAN_SEL_LSB +: CHAN_SEL_W];
    assign ext_irq0_pin_select   = ext_irq_control_reg[IRQ0_SEL_BIT];
    assign analog_onehot = analog_input_disable ? 8'h00 :
                           (8'h01 << analog_channel_select);

    // APB answer: zero wait, error on unmapped or read-only write
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && read_only));
    assign prdata  = prdata_reg;

    // ------------------------------------------------------------------
    // Register writes, taken at the access edge
    // ------------------------------------------------------------------
    // Update in access phase
    always_comb begin
        port0_out_latch_next = port0_out_latch_reg;
        port1_out_latch_next = port1_out_latch_reg;
        port2_out_latch_next = port2_out_latch_reg;
        port3_out_latch_next = port3_out_latch_reg;
        port4_out_latch_next = port4_out_latch_reg;
        port1_direction_next = port1_direction_reg;
        port3_direction_next = port3_direction_reg;
        port4_direction_next = port4_direction_reg;
        conv_ctrl_next       = conv_ctrl_reg;
        ext_irq_control_next = ext_irq_control_reg;
        if (write_access) begin
            unique case (idx)
                IDX_PORT0_LATCH:  port0_out_latch_next = pwdata[P0_W-1:0];
                IDX_PORT1_LATCH:  port1_out_latch_next = pwdata[P1_W-1:0];
                IDX_PORT2_LATCH:  port2_out_latch_next = pwdata[P2_W-1:0];
                IDX_PORT3_LATCH:  port3_out_latch_next = pwdata[P3_W-1:0];
                IDX_PORT4_LATCH:  port4_out_latch_next = pwdata[P4_W-1:0];
                IDX_PORT1_DIR:    port1_direction_next = pwdata[P1_W-1:0];
                IDX_PORT3_DIR:    port3_direction_next = pwdata[P3_W-1:0];
                IDX_PORT4_DIR:    port4_direction_next = pwdata[P4_W-1:0];
                IDX_CONV_CTRL1:   conv_ctrl_next       = pwdata[7:0];
                IDX_EXT_IRQ_CTRL: ext_irq_control_next = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port0_out_latch_reg <= RST_PORT0_LATCH;
            port1_out_latch_reg <= RST_PORT1_LATCH;
            port2_out_latch_reg <= RST_PORT2_LATCH;
            port3_out_latch_reg <= RST_PORT3_LATCH;
            port4_out_latch_reg <= RST_PORT4_LATCH;
            port1_direction_reg <= RST_DIR[P1_W-1:0];
            port3_direction_reg <= RST_DIR[P3_W-1:0];
            port4_direction_reg <= RST_DIR[P4_W-1:0];
            conv_ctrl_reg       <= RST_CONV_CTRL1;
            ext_irq_control_reg <= RST_EXT_IRQ;
        end else begin
            port0_out_latch_reg <= port0_out_latch_next;
            port1_out_latch_reg <= port1_out_latch_next;
            port2_out_latch_reg <= port2_out_latch_next;
            port3_out_latch_reg <= port3_out_latch_next;
            port4_out_latch_reg <= port4_out_latch_next;
            port1_direction_reg <= port1_direction_next;
            port3_direction_reg <= port3_direction_next;
            port4_direction_reg <= port4_direction_next;
            conv_ctrl_reg       <= conv_ctrl_next;
            ext_irq_control_reg <= ext_irq_control_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Pin or latch per direction
    assign p1_read = mix_read({2'b00, port1_pin_in},
                              {2'b00, port1_out_latch_reg},
                              {2'b00, port1_direction_reg});
    assign p4_read = mix_read(port4_pin_in, port4_out_latch_reg,
                              port4_direction_reg);
    assign p3_read = mix_read(port3_pin_in, port3_out_latch_reg,
                              port3_direction_reg) & ~analog_onehot;

    // Read selection; undefined bits read zero
    always_comb begin
        read_value = 8'h00;
        unique case (idx)
            IDX_PORT0_LATCH:  read_value = port0_out_latch_reg;
            IDX_PORT1_LATCH:  read_value = p1_read;
            IDX_PORT2_LATCH:  read_value = {5'h00, port2_out_latch_reg};
            IDX_PORT3_LATCH:  read_value = p3_read;
            IDX_PORT4_LATCH:  read_value = p4_read;
            IDX_PORT0_PIN:    read_value = port0_pin_in;
            IDX_PORT2_PIN:    read_value = {5'h00, port2_pin_in};
            IDX_PORT1_DIR:    read_value = {2'b00, port1_direction_reg};
            IDX_PORT3_DIR:    read_value = port3_direction_reg;
            IDX_PORT4_DIR:    read_value = port4_direction_reg;
            IDX_CONV_CTRL1:   read_value = conv_ctrl_reg;
            IDX_EXT_IRQ_CTRL: read_value = ext_irq_control_reg;
            default:          read_value = 8'h00;
        endcase
    end

    // Pins sampled at the setup edge, held through access
    always_comb begin
        prdata_next = prdata_reg;
        if (setup_phase && !pwrite) begin
            prdata_next = {24'h000000, read_value};
        end
    end

    // Read data holding register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Port 0: a zero latch pulls low; bit 0 freed for irq
    assign port0_pin_out = '0;
    assign port0_pin_oe  = ~port0_out_latch_reg &
                           {{(P0_W-1){1'b1}}, !ext_irq0_pin_select};
    // Port 1 drives its latch where direction is 1
    assign port1_pin_out = port1_out_latch_reg;
    assign port1_pin_oe  = port1_direction_reg;
    // Port 2 open drain; crystal bits released in dual-clock mode
    assign port2_pin_out = '0;
    assign port2_pin_oe  = ~port2_out_latch_reg &
                           {!dual_clock_mode, !dual_clock_mode, 1'b1};
    // Port 3 analog pin never driven
    assign port3_pin_out = port3_out_latch_reg;
    assign port3_pin_oe  = port3_direction_reg & ~analog_onehot;
    assign port4_pin_out = port4_out_latch_reg;
    assign port4_pin_oe  = port4_direction_reg;

    // Secondary-function taps
    // Interrupt 0 sees the pin only when selected
    assign ext_irq0_input    = ext_irq0_pin_select ? port0_pin_in[0] : 1'b1;
    // Pin level, so its own driven falls reach the irq edge logic
    assign ext_irq5_input    = port2_pin_in[0];
    assign low_freq_xtal_in  = dual_clock_mode & port2_pin_in[XTAL_IN_BIT];
    assign analog_pin_select = analog_onehot;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Setup-phase read qualifier for assertion use
    logic rd_setup;
    assign rd_setup = setup_phase && !pwrite;

    a_reset_latch_values: assert property (
        $rose(rst_n) |-> port0_out_latch_reg == 8'hff &&
            port2_out_latch_reg == 3'h7 && port1_direction_reg == 6'h00)
        else $error("latch reset values wrong");
    a_p1_write_edge: assert property (
        (write_access && idx == IDX_PORT1_LATCH) |=>
            port1_pin_out == $past(pwdata[5:0]))
        else $error("port 1 write not applied at access edge");
    a_p0_drive_low: assert property (
        port0_pin_oe[7:1] == ~port0_out_latch_reg[7:1])
        else $error("port 0 drive does not follow latch");
    a_p1_dir_drive: assert property (
        port1_pin_oe == port1_direction_reg)
        else $error("port 1 enable not equal to direction");
    a_read_sample_s1: assert property (
        (rd_setup && idx == IDX_PORT0_PIN) |=>
            prdata[7:0] == $past(port0_pin_in) && prdata[31:8] == 24'h0)
        else $error("port 0 pin read not taken at setup");
    a_irq0_pin_input: assert property (
        ext_irq0_pin_select |-> !port0_pin_oe[0])
        else $error("interrupt 0 pin still driven");
    a_p3_analog_free: assert property (
        !analog_input_disable |->
            !port3_pin_oe[analog_channel_select])
        else $error("analog pin driven");
    a_p3_analog_zero: assert property (
        (rd_setup && idx == IDX_PORT3_LATCH && !analog_input_disable) |=>
            prdata[$past(analog_channel_select)] == 1'b0)
        else $error("analog pin read not zero");
    a_p2_upper_zero: assert property (
        (rd_setup && (idx == IDX_PORT2_PIN || idx == IDX_PORT2_LATCH)) |=>
            prdata[7:3] == 5'h00)
        else $error("port 2 upper bits not zero");
    a_p4_latch_any_dir: assert property (
        (write_access && idx == IDX_PORT4_LATCH) ##1 !write_access |->
            port4_pin_out == $past(pwdata[7:0], 2))
        else $error("port 4 latch write lost");
    a_p4_read_mix: assert property (
        (rd_setup && idx == IDX_PORT4_LATCH) |=>
            prdata[7:0] == (($past(port4_pin_in) & ~$past(port4_pin_oe)) |
                            ($past(port4_pin_out) & $past(port4_pin_oe))))
        else $error("port 4 read mix wrong");

    c_p0_pin_read:   cover property (rd_setup && idx == IDX_PORT0_PIN);
    c_p3_analog_rd:  cover property (rd_setup && idx == IDX_PORT3_LATCH &&
                                     !analog_input_disable);
    c_irq0_selected: cover property ($rose(ext_irq0_pin_select));
    c_slave_error:   cover property (pslverr);

endmodule : pio_ports

// *** pkg/pio_pkg.sv ***
// Register indices, field positions and reset values of the parallel ports
package pio_pkg;
    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_PORT0_LATCH  = 6'h00;
    localparam logic [5:0] IDX_PORT1_LATCH  = 6'h01;
    localparam logic [5:0] IDX_PORT2_LATCH  = 6'h02;
    localparam logic [5:0] IDX_PORT3_LATCH  = 6'h03;
    localparam logic [5:0] IDX_PORT4_LATCH  = 6'h04;
    localparam logic [5:0] IDX_PORT0_PIN    = 6'h08;
    localparam logic [5:0] IDX_PORT2_PIN    = 6'h0a;
    localparam logic [5:0] IDX_PORT1_DIR    = 6'h0d;
    localparam logic [5:0] IDX_PORT3_DIR    = 6'h0e;
    localparam logic [5:0] IDX_PORT4_DIR    = 6'h0f;
    localparam logic [5:0] IDX_CONV_CTRL1   = 6'h1c;
    localparam logic [5:0] IDX_EXT_IRQ_CTRL = 6'h37;
    // ------------------------------------------------------------------
    // Port widths
    // ------------------------------------------------------------------
    localparam int P0_W = 8;
    localparam int P1_W = 6;
    localparam int P2_W = 3;
    localparam int P3_W = 8;
    localparam int P4_W = 8;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IRQ0_SEL_BIT    = 6;
    localparam int AIN_DISABLE_BIT = 4;
    localparam int CHAN_SEL_LSB    = 0;
    localparam int CHAN_SEL_W      = 3;
    localparam int XTAL_IN_BIT     = 1;
    localparam int XTAL_OUT_BIT    = 2;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PORT0_LATCH = 8'hff;
    localparam logic [5:0] RST_PORT1_LATCH = 6'h00;
    localparam logic [2:0] RST_PORT2_LATCH = 3'h7;
    localparam logic [7:0] RST_PORT3_LATCH = 8'h00;
    localparam logic [7:0] RST_PORT4_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR         = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL1  = 8'h10;
    localparam logic [7:0] RST_EXT_IRQ     = 8'h00;
endpackage : pio_pkg

// *** test/pio_ports_bench.sv ***
// Self-checking bench for the parallel I/O ports over APB
`timescale 1ns/10ps
module pio_ports_bench;
    import pio_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, dual_clock_mode = 1'b0;
    logic [7:0]  p0_in = 8'h3c, p0_out, p0_oe, p3_in = 8'hff, p3_out, p3_oe;
    logic [7:0]  p4_in = 8'h3c, p4_out, p4_oe, ana_sel;
    logic [5:0]  p1_in = 6'h15, p1_out, p1_oe;
    logic [2:0]  p2_in = 3'h5, p2_out, p2_oe;
    logic        irq0, irq5, xtal;
    int          n_fail = 0;
    int          check_count = 0;
    logic [5:0]  idx_tab [7] = '{IDX_PORT0_LATCH, IDX_PORT2_LATCH,
        IDX_PORT1_DIR, IDX_PORT3_DIR, IDX_PORT4_DIR, IDX_CONV_CTRL1,
        IDX_EXT_IRQ_CTRL};
    logic [7:0]  rst_tab [7] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00,
        8'h10, 8'h00};

    pio_ports #(.ADDR_W(8)) dut_u (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port0_pin_in(p0_in), .port0_pin_out(p0_out),
        .port0_pin_oe(p0_oe), .port1_pin_in(p1_in), .port1_pin_out(p1_out),
        .port1_pin_oe(p1_oe), .port2_pin_in(p2_in), .port2_pin_out(p2_out),
        .port2_pin_oe(p2_oe), .port3_pin_in(p3_in), .port3_pin_out(p3_out),
        .port3_pin_oe(p3_oe), .port4_pin_in(p4_in), .port4_pin_out(p4_out),
        .port4_pin_oe(p4_oe), .dual_clock_mode(dual_clock_mode),
        .ext_irq0_input(irq0), .ext_irq5_input(irq5),
        .low_freq_xtal_in(xtal), .analog_pin_select(ana_sel));

    // Clock at 50 MHz
    always #10 clock = ~clock;

    task automatic close_out();
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic xfer(input logic wr, input logic [5:0] idx,
                        input logic [7:0] wd, input logic [7:0] exp,
                        input logic exp_err);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        if (!wr) chk(prdata, {24'h0, exp});
        chk({31'h0, pslverr}, {31'h0, exp_err});
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : xfer

    // Watchdog: the tests take about a hundred cycles
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk(32'({p0_oe, p1_oe, p2_oe, p3_oe}), 32'h0);
        chk(32'(p4_oe), 32'h0);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, idx_tab[i], 8'h00, rst_tab[i], 1'b0);
        end
        // Port 0: latch and pin registers apart, open-drain low
        xfer(1'b1, IDX_PORT0_LATCH, 8'h5a, 8'h00, 1'b0);
        chk(32'({p0_out, p0_oe}), 32'h00a5);
        xfer(1'b1, IDX_PORT0_PIN, 8'h00, 8'h00, 1'b1);
        xfer(1'b0, IDX_PORT0_LATCH, 8'h00, 8'h5a, 1'b0);
        // Pin moves on the setup edge; the old level must be returned
        fork
            xfer(1'b0, IDX_PORT0_PIN, 8'h00, 8'h3c, 1'b0);
            begin
                repeat (2) @(posedge clock);
                p0_in <= 8'hc2;
            end
        join
        xfer(1'b1, IDX_EXT_IRQ_CTRL, 8'h40, 8'h00, 1'b0);
        xfer(1'b1, IDX_PORT0_LATCH, 8'h00, 8'h00, 1'b0);
        chk(32'({p0_oe, 7'h0, irq0}), 32'hfe00);
        xfer(1'b1, IDX_EXT_IRQ_CTRL, 8'h00, 8'h00, 1'b0);
        chk(32'({p0_oe, 7'h0, irq0}), 32'hff01);
        // Port 1: latch taken while input, then mixed direction
        xfer(1'b1, IDX_PORT1_LATCH, 8'h2a, 8'h00, 1'b0);
        chk(32'({p1_oe, 2'b0, p1_out}), 32'h002a);
        xfer(1'b0, IDX_PORT1_LATCH, 8'h00, 8'h15, 1'b0);
        xfer(1'b1, IDX_PORT1_DIR, 8'h0f, 8'h00, 1'b0);
        chk(32'({p1_oe, 2'b0, p1_out}), 32'h0f2a);
        xfer(1'b0, IDX_PORT1_LATCH, 8'h00, 8'h1a, 1'b0);
        xfer(1'b0, IDX_PORT1_DIR, 8'h00, 8'h0f, 1'b0);
        // Port 4: mixed read of latch and pins
        xfer(1'b1, IDX_PORT4_LATCH, 8'ha5, 8'h00, 1'b0);
        xfer(1'b1, IDX_PORT4_DIR, 8'h0f, 8'h00, 1'b0);
        chk(32'({p4_oe, p4_out}), 32'h0fa5);
        xfer(1'b0, IDX_PORT4_LATCH, 8'h00, 8'h35, 1'b0);
        // Port 2: open-drain, crystal pins in dual-clock mode
        xfer(1'b1, IDX_PORT2_LATCH, 8'h02, 8'h00, 1'b0);
        chk(32'({5'h0, p2_oe, 5'h0, p2_out}), 32'h0500);
        // Mode and pins change at an edge, like every other input
        @(posedge clock);
        dual_clock_mode <= 1'b1;
        p2_in           <= 3'h2;
        @(posedge clock);
        #1;
        chk(32'({p2_oe, irq5, xtal}), 32'h05);
        xfer(1'b0, IDX_PORT2_PIN, 8'h00, 8'h02, 1'b0);
        xfer(1'b1, IDX_PORT2_PIN, 8'h00, 8'h00, 1'b1);
        xfer(1'b0, IDX_PORT2_LATCH, 8'h00, 8'h02, 1'b0);
        // Port 3: analog channel 3 overrides direction and reads 0
        xfer(1'b1, IDX_PORT3_LATCH, 8'hff, 8'h00, 1'b0);
        xfer(1'b1, IDX_PORT3_DIR, 8'hff, 8'h00, 1'b0);
        xfer(1'b1, IDX_CONV_CTRL1, 8'h03, 8'h00, 1'b0);
        chk(32'({ana_sel, p3_oe}), 32'h08f7);
        xfer(1'b0, IDX_PORT3_LATCH, 8'h00, 8'hf7, 1'b0);
        xfer(1'b1, IDX_CONV_CTRL1, 8'h13, 8'h00, 1'b0);
        chk(32'({ana_sel, p3_oe}), 32'h00ff);
        chk(32'(p3_out), 32'h000000ff);
        // Unmapped word is refused and reads zero
        xfer(1'b0, 6'h05, 8'h00, 8'h00, 1'b1);
        close_out();
    end
endmodule : pio_ports_bench
